// [rtl/alt_defs.svh]
// Constants for the analog level trigger detector.
// Assumes inclusion by bare name from the design files.
`ifndef ALT_DEFS_SVH
`define ALT_DEFS_SVH

// ------------------------------------------------------------
// Mode encodings
// ------------------------------------------------------------
`define ALT_MODE_BELOW    3'h0
`define ALT_MODE_ABOVE    3'h1
`define ALT_MODE_HYS_RISE 3'h2
`define ALT_MODE_HYS_FALL 3'h3
`define ALT_MODE_WIN_IN   3'h4
`define ALT_MODE_WIN_OUT  3'h5

// ------------------------------------------------------------
// Source select encodings
// ------------------------------------------------------------
`define ALT_SRC_PIN0 2'h0
`define ALT_SRC_PIN1 2'h1
`define ALT_SRC_CHAN 2'h2

// ------------------------------------------------------------
// Gain shift limit and reset values
// ------------------------------------------------------------
`define ALT_GAIN_SHIFT_MAX 3'h7
`define ALT_FLAG_CLEAR     1'b0

`endif

// [rtl/alt_gain_stage.sv]
// Programmable gain stage placed ahead of the comparator.
// Assumes a signed two's complement sample; gain is a power of two, saturating.
`timescale 1ns/1ps
`include "alt_defs.svh"

module alt_gain_stage
#(
  parameter int W = 16
)
(
  input  wire logic         sys_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] sample_i,
  input  wire logic         valid_i,
  input  wire logic [2:0]   gain_shift_i,
  output logic      [W-1:0] sample_o,
  output logic              valid_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed
  {
    logic [W-1:0] data;
    logic         vld;
  } alt_gain_state_t;

  alt_gain_state_t st_reg;
  alt_gain_state_t st_next;

  // Saturating shift: clipping beats wrap-around, which would fake a crossing
  function automatic logic [W-1:0] sat_shift(input logic [W-1:0] x, input logic [2:0] sh);
    logic signed [W+7:0] wide;
    logic signed [W+7:0] maxv;
    logic signed [W+7:0] minv;
    wide = (W+8)'($signed(x)) <<< sh;
    maxv = (W+8)'({1'b0, {(W-1){1'b1}}});
    minv = -maxv - (W+8)'(1);
    if (wide > maxv)
      sat_shift = maxv[W-1:0];
    else if (wide < minv)
      sat_shift = minv[W-1:0];
    else
      sat_shift = wide[W-1:0];
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next      = st_reg;
    st_next.vld  = valid_i;
    if (valid_i)
      st_next.data = sat_shift(sample_i, gain_shift_i); // [RQ13]
  end

  // Register the state
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign sample_o = st_reg.data;
  assign valid_o  = st_reg.vld;

endmodule

// [rtl/alt_pkg.sv]
// Types shared by the analog level trigger design.
// Assumes alt_defs.svh supplies the numeric encodings.
package alt_pkg;

  // ------------------------------------------------------------
  // Detector state: one-hot
  // ------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ALT_ST_IDLE  = 3'b001,
    ALT_ST_ARMED = 3'b010,
    ALT_ST_FIRED = 3'b100
  } alt_state_t;

endpackage

// [rtl/alt_trigger.sv]
// Analog level trigger detector: level, hysteresis and window modes.
// Assumes digitized samples arrive synchronous to sys_clk_i with a valid strobe.
//
// Summary of operation
// RQ1 - Below-level mode fires while source is strictly under the level.
// RQ2 - Above-level mode fires while source is strictly over the level.
// RQ3 - Rising hysteresis: upper threshold is level, lower is level minus hysteresis.
// RQ4 - Rising hysteresis fires after source went under lower, then over upper.
// RQ5 - Rising hysteresis event holds until source falls back under lower threshold.
// RQ6 - Falling hysteresis: lower threshold is level, upper is level plus hysteresis.
// RQ7 - Falling hysteresis fires after source went over upper, then under lower.
// RQ8 - Falling hysteresis event holds until source rises back over upper threshold.
// RQ9 - The one output is the comparison event signal; the code also drives armed_o.
// RQ10 - Window mode fires on entering, or as configured leaving, the band.
// RQ11 - The band has separately programmable top and bottom limits.
// RQ12 - Comparison uses programmable references updated when level or limits are written.
// RQ13 - Pin sources compare without gain; channel sources go through the amplifier.
// RQ14 - Source selects one of two trigger pins or an input channel.
// RQ15 - Each new sample is evaluated on the clock edge; arming state is registered.
// RQ16 - Reset or a mode or threshold change clears event and arming state.
`timescale 1ns/1ps
`include "alt_defs.svh"

module alt_trigger
  import alt_pkg::*;
#(
  parameter int W = 16
)
(
  input  wire logic         sys_clk_i,
  input  wire logic         reset_i,
  input  wire logic [W-1:0] analog_trigger_pin0_i,
  input  wire logic [W-1:0] analog_trigger_pin1_i,
  input  wire logic         pin_valid_i,
  input  wire logic [W-1:0] chan_sample_i,
  input  wire logic         chan_valid_i,
  input  wire logic [2:0]   amp_gain_shift_i,
  input  wire logic [1:0]   source_sel_i,
  input  wire logic [2:0]   mode_i,
  input  wire logic [W-1:0] level_i,
  input  wire logic [W-1:0] hysteresis_i,
  input  wire logic [W-1:0] window_top_i,
  input  wire logic [W-1:0] window_bottom_i,
  input  wire logic         ref_write_i,
  output logic              comparison_event_o,
  output logic              armed_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed
  {
    alt_state_t   fsm;
    logic         evt;
    logic         prev_in;
    logic         prev_ok;
    logic [2:0]   mode;
    logic [1:0]   src;
    logic [W-1:0] lvl;
    logic [W-1:0] hys;
    logic [W-1:0] top;
    logic [W-1:0] bot;
  } alt_core_state_t;

  alt_core_state_t st_reg;
  alt_core_state_t st_next;

  logic [W-1:0] amp_sample;
  logic         amp_valid;
  logic [W-1:0] src_sample;
  logic         src_valid;

  // ------------------------------------------------------------
  // Amplifier on the channel path only
  // ------------------------------------------------------------
  alt_gain_stage
  #(
    .W (W)
  )
  u_programmable_gain_amp
  (
    .sys_clk_i    (sys_clk_i),
    .reset_i      (reset_i),
    .sample_i     (chan_sample_i),
    .valid_i      (chan_valid_i),
    .gain_shift_i (amp_gain_shift_i),
    .sample_o     (amp_sample),
    .valid_o      (amp_valid)
  );

  // Saturating signed add/sub keeps thresholds from wrapping past full scale
  function automatic logic [W-1:0] sat_addsub(input logic [W-1:0] a,
                                              input logic [W-1:0] b,
                                              input logic sub);
    logic signed [W:0] r;
    logic signed [W:0] maxv;
    logic signed [W:0] minv;
    r    = sub ? ((W+1)'($signed(a)) - (W+1)'($signed(b)))
               : ((W+1)'($signed(a)) + (W+1)'($signed(b)));
    maxv = (W+1)'({1'b0, {(W-1){1'b1}}});
    minv = -maxv - (W+1)'(1);
    if (r > maxv)
      sat_addsub = maxv[W-1:0];
    else if (r < minv)
      sat_addsub = minv[W-1:0];
    else
      sat_addsub = r[W-1:0];
  endfunction

  // Strict signed less-than, shared by every comparison
  function automatic logic s_lt(input logic [W-1:0] a, input logic [W-1:0] b);
    s_lt = $signed(a) < $signed(b);
  endfunction

  // ------------------------------------------------------------
  // Source selection
  // ------------------------------------------------------------
  always_comb
  begin
    src_sample = analog_trigger_pin0_i;
    src_valid  = pin_valid_i;
    unique case (st_reg.src)
      `ALT_SRC_PIN0:
      begin
        src_sample = analog_trigger_pin0_i; // [RQ14] [RQ13]
        src_valid  = pin_valid_i;
      end
      `ALT_SRC_PIN1:
      begin
        src_sample = analog_trigger_pin1_i; // [RQ14] [RQ13]
        src_valid  = pin_valid_i;
      end
      default:
      begin
        src_sample = amp_sample;            // [RQ14] [RQ13]
        src_valid  = amp_valid;
      end
    endcase
  end

  // ------------------------------------------------------------
  // Detection
  // ------------------------------------------------------------
  // Thresholds come from latched references so a half-written set never steers
  always_comb
  begin
    logic [W-1:0] hi;
    logic [W-1:0] lo;
    logic         in_band;
    logic         cfg_change;
    hi         = st_reg.lvl;
    lo         = st_reg.lvl;
    in_band    = 1'b0;
    cfg_change = 1'b0;
    st_next    = st_reg;

    // Reference update on write; a write or a mode or source change restarts detection
    cfg_change = (mode_i != st_reg.mode) || (source_sel_i != st_reg.src);
    if (ref_write_i)
    begin
      st_next.lvl = level_i;                 // [RQ12]
      st_next.hys = hysteresis_i;
      st_next.top = window_top_i;            // [RQ11]
      st_next.bot = window_bottom_i;         // [RQ11]
      cfg_change  = 1'b1;
    end
    st_next.mode = mode_i;
    st_next.src  = source_sel_i;

    if (st_reg.mode == `ALT_MODE_HYS_RISE)
      lo = sat_addsub(st_reg.lvl, st_reg.hys, 1'b1); // [RQ3]
    if (st_reg.mode == `ALT_MODE_HYS_FALL)
      hi = sat_addsub(st_reg.lvl, st_reg.hys, 1'b0); // [RQ6]
    in_band = !s_lt(src_sample, st_reg.bot) && !s_lt(st_reg.top, src_sample);

    if (cfg_change)
    begin
      st_next.fsm     = ALT_ST_IDLE;         // [RQ16]
      st_next.evt     = `ALT_FLAG_CLEAR;
      st_next.prev_ok = `ALT_FLAG_CLEAR;
    end
    else if (src_valid)                      // [RQ15]
    begin
      st_next.prev_in = in_band;
      st_next.prev_ok = 1'b1;
      unique case (st_reg.mode)
        `ALT_MODE_BELOW:
          st_next.evt = s_lt(src_sample, st_reg.lvl);   // [RQ1]
        `ALT_MODE_ABOVE:
          st_next.evt = s_lt(st_reg.lvl, src_sample);   // [RQ2]
        `ALT_MODE_HYS_RISE:
        begin
          unique case (st_reg.fsm)
            ALT_ST_IDLE:
              if (s_lt(src_sample, lo))
                st_next.fsm = ALT_ST_ARMED;             // [RQ4]
            ALT_ST_ARMED:
              if (s_lt(hi, src_sample))
                st_next.fsm = ALT_ST_FIRED;             // [RQ4]
            default:
              if (s_lt(src_sample, lo))
                st_next.fsm = ALT_ST_ARMED;             // [RQ5]
          endcase
          st_next.evt = (st_next.fsm == ALT_ST_FIRED);
        end
        `ALT_MODE_HYS_FALL:
        begin
          unique case (st_reg.fsm)
            ALT_ST_IDLE:
              if (s_lt(hi, src_sample))
                st_next.fsm = ALT_ST_ARMED;             // [RQ7]
            ALT_ST_ARMED:
              if (s_lt(src_sample, lo))
                st_next.fsm = ALT_ST_FIRED;             // [RQ7]
            default:
              if (s_lt(hi, src_sample))
                st_next.fsm = ALT_ST_ARMED;             // [RQ8]
          endcase
          st_next.evt = (st_next.fsm == ALT_ST_FIRED);
        end
        `ALT_MODE_WIN_IN:
          // One-sample pulse on the crossing into the band
          st_next.evt = st_reg.prev_ok && !st_reg.prev_in && in_band;  // [RQ10]
        `ALT_MODE_WIN_OUT:
          st_next.evt = st_reg.prev_ok && st_reg.prev_in && !in_band;  // [RQ10]
        default:
          st_next.evt = `ALT_FLAG_CLEAR;
      endcase
    end
    else if (st_reg.mode == `ALT_MODE_WIN_IN || st_reg.mode == `ALT_MODE_WIN_OUT)
      st_next.evt = `ALT_FLAG_CLEAR;         // Crossing pulse lasts one cycle
  end

  // Register the state
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      st_reg      <= '0;
      st_reg.fsm  <= ALT_ST_IDLE;            // [RQ16]
    end
    else
      st_reg <= st_next;
  end

  assign comparison_event_o = st_reg.evt;    // [RQ9]
  assign armed_o            = (st_reg.fsm == ALT_ST_ARMED);

endmodule

// [tb/alt_src_model.sv]
// Source sampler model: one sample on the selected pin or channel.
// Assumes the bench moves go_i and val_i at the falling edge.
`timescale 1ns/1ps
module alt_src_model
#(
  parameter int W = 16
)
(
  input  wire logic         sys_clk_i,
  input  wire logic         go_i,
  input  wire logic [1:0]   sel_i,
  input  wire logic [W-1:0] val_i,
  output logic      [W-1:0] pin0_o,
  output logic      [W-1:0] pin1_o,
  output logic              pin_valid_o,
  output logic      [W-1:0] chan_o,
  output logic              chan_valid_o
);
  logic [W-1:0] last_reg = '0;
  // Idle lines carry the inverse of the last sample so stale data never matches
  always_ff @(posedge sys_clk_i)
  begin
    if (go_i) last_reg <= val_i;
  end
  assign pin0_o = (go_i && sel_i == 2'h0) ? val_i : ~last_reg;
  assign pin1_o = (go_i && sel_i == 2'h1) ? val_i : ~last_reg;
  assign chan_o = (go_i && sel_i[1]) ? val_i : ~last_reg;
  assign pin_valid_o = go_i && !sel_i[1];
  assign chan_valid_o = go_i && sel_i[1];
endmodule

// [tb/alt_trigger_props.sv]
// Assertions on the trigger detector ports.
// Assumes a bind onto alt_trigger, one clock and an async reset.
`timescale 1ns/1ps
module alt_trigger_props
  import alt_pkg::*;
#(
  parameter int W = 16
)
(
  input wire logic         sys_clk_i,
  input wire logic         reset_i,
  input wire logic [W-1:0] analog_trigger_pin0_i,
  input wire logic [W-1:0] analog_trigger_pin1_i,
  input wire logic         pin_valid_i,
  input wire logic [W-1:0] chan_sample_i,
  input wire logic         chan_valid_i,
  input wire logic [2:0]   amp_gain_shift_i,
  input wire logic [1:0]   source_sel_i,
  input wire logic [2:0]   mode_i,
  input wire logic [W-1:0] level_i,
  input wire logic [W-1:0] hysteresis_i,
  input wire logic [W-1:0] window_top_i,
  input wire logic [W-1:0] window_bottom_i,
  input wire logic         ref_write_i,
  input wire logic         comparison_event_o,
  input wire logic         armed_o
);
  logic [2:0]   m_reg;
  logic [1:0]   s_reg;
  logic [W-1:0] l_reg;
  logic [W-1:0] h_reg;
  logic         lt_reg;
  logic         gt_reg;
  logic [W-1:0] pin;
  logic         ok;
  // A pin sample counts only when no setting changes in its cycle
  assign pin = source_sel_i[0] ? analog_trigger_pin1_i : analog_trigger_pin0_i;
  assign ok = pin_valid_i && !source_sel_i[1] && !ref_write_i && mode_i == m_reg
              && source_sel_i == s_reg;
  // Mirrors of the mode, source, level and hysteresis registers, and the registered pin comparisons
  always_ff @(posedge sys_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      m_reg <= 3'h0;
      s_reg <= 2'h0;
      l_reg <= '0;
      h_reg <= '0;
      lt_reg <= 1'b0;
      gt_reg <= 1'b0;
    end
    else
    begin
      m_reg <= mode_i;
      s_reg <= source_sel_i;
      if (ref_write_i) l_reg <= level_i;
      if (ref_write_i) h_reg <= hysteresis_i;
      lt_reg <= $signed(pin) < $signed(l_reg);
      gt_reg <= $signed(pin) > $signed(l_reg);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  a_below_level: assert property (ok && mode_i == 3'h0 |=> comparison_event_o == lt_reg)
    else $error("below-level event wrong");
  a_above_level: assert property (ok && mode_i == 3'h1 |=> comparison_event_o == gt_reg)
    else $error("above-level event wrong");
  a_rise_fires: assert property (ok && mode_i == 3'h2 && armed_o && $signed(pin) > $signed(l_reg)
    |=> comparison_event_o && !armed_o) else $error("rising slope did not fire");
  a_rise_holds: assert property (ok && mode_i == 3'h2 && comparison_event_o
    && $signed(pin) >= $signed(l_reg - h_reg) |=> comparison_event_o) else $error("rise dropped");
  a_fall_fires: assert property (ok && mode_i == 3'h3 && armed_o && $signed(pin) < $signed(l_reg)
    |=> comparison_event_o) else $error("falling slope did not fire");
  a_window_pulse: assert property (m_reg[2:1] == 2'b10 && comparison_event_o
    |=> !comparison_event_o) else $error("window event longer than a cycle");
  a_config_clears: assert property (mode_i != m_reg || source_sel_i != s_reg || ref_write_i
    |=> !comparison_event_o && !armed_o) else $error("change did not clear");
  a_spare_modes: assert property (m_reg[2:1] == 2'b11 |-> !comparison_event_o)
    else $error("event in unused mode");
  c_rise: cover property (ok && mode_i == 3'h2 && armed_o ##1 comparison_event_o);
  c_win: cover property (m_reg[2:1] == 2'b10 && comparison_event_o);
  c_clear: cover property (ref_write_i && comparison_event_o);
endmodule
bind alt_trigger alt_trigger_props #(.W(W)) alt_trigger_props_i (.sys_clk_i(sys_clk_i),
  .reset_i(reset_i), .analog_trigger_pin0_i(analog_trigger_pin0_i),
  .analog_trigger_pin1_i(analog_trigger_pin1_i), .pin_valid_i(pin_valid_i),
  .chan_sample_i(chan_sample_i), .chan_valid_i(chan_valid_i),
  .amp_gain_shift_i(amp_gain_shift_i), .source_sel_i(source_sel_i), .mode_i(mode_i),
  .level_i(level_i), .hysteresis_i(hysteresis_i), .window_top_i(window_top_i),
  .window_bottom_i(window_bottom_i), .ref_write_i(ref_write_i),
  .comparison_event_o(comparison_event_o), .armed_o(armed_o));

// [tb/alt_trigger_test.sv]
// Self-checking bench for the level trigger detector.
// Assumes the design, the source model and the checker are compiled first.
`timescale 1ns/1ps
module alt_trigger_test;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        go = 1'b0;
  logic        wr = 1'b0;
  logic [1:0]  sel = 2'h0;
  logic [2:0]  gain = 3'h0;
  logic [2:0]  mode = 3'h0;
  logic [15:0] val = 16'h0000;
  logic [15:0] lvl = 16'h0000;
  logic [15:0] hys = 16'h0000;
  logic [15:0] top = 16'h0000;
  logic [15:0] bot = 16'h0000;
  logic [15:0] seed = 16'h0034;
  logic [15:0] p0, p1, ch;
  logic        pv, cv, ev_o, arm_o;
  int          fail_count = 0;
  int          n_tests = 0;
  int          st, ev, pb, ph, md, lv, hy, tp, bt;
  int          list[14] = '{130, 70, 130, 90, 70, 100, 101, 5, 0, 10, 11, -1, 121, 99};
  always #4 sys_clk_i = ~sys_clk_i;
  alt_src_model #(.W(16)) alt_src_model_i (.sys_clk_i(sys_clk_i), .go_i(go), .sel_i(sel),
    .val_i(val), .pin0_o(p0), .pin1_o(p1), .pin_valid_o(pv), .chan_o(ch), .chan_valid_o(cv));
  alt_trigger #(.W(16)) alt_trigger_i (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .analog_trigger_pin0_i(p0), .analog_trigger_pin1_i(p1), .pin_valid_i(pv),
    .chan_sample_i(ch), .chan_valid_i(cv), .amp_gain_shift_i(gain), .source_sel_i(sel),
    .mode_i(mode), .level_i(lvl), .hysteresis_i(hys), .window_top_i(top),
    .window_bottom_i(bot), .ref_write_i(wr), .comparison_event_o(ev_o), .armed_o(arm_o));
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Settings change with a reference write; no sample rides in that cycle
  task automatic cfg(input int m, input int s, input int g);
    @(negedge sys_clk_i);
    mode = 3'(m);
    sel = 2'(s);
    gain = 3'(g);
    lvl = 16'(lv);
    hys = 16'(hy);
    top = 16'(tp);
    bot = 16'(bt);
    wr = 1'b1;
    @(negedge sys_clk_i);
    wr = 1'b0;
    @(negedge sys_clk_i);
    chk(ev_o, 1'b0);
    chk(arm_o, 1'b0);
    md = m;
    st = 0;
    ph = 0;
  endtask
  // One sample through the model, then the check once the answer has landed
  task automatic smp(input int v);
    int x;
    int b;
    x = sel[1] ? v * (1 << gain) : v;
    x = (x > 32767) ? 32767 : (x < -32768) ? -32768 : x;
    b = x >= bt && x <= tp;
    case (md)
      0: ev = x < lv;
      1: ev = x > lv;
      2: st = (x < lv - hy) ? 1 : (st == 1 && x > lv) ? 2 : st;
      3: st = (x > lv + hy) ? 1 : (st == 1 && x < lv) ? 2 : st;
      4: ev = ph && b && !pb;
      5: ev = ph && !b && pb;
      default: ev = 0;
    endcase
    if (md == 2 || md == 3) ev = (st == 2);
    pb = b;
    ph = 1;
    @(negedge sys_clk_i);
    val = 16'(v);
    go = 1'b1;
    @(negedge sys_clk_i);
    go = 1'b0;
    if (sel[1]) @(negedge sys_clk_i);
    chk(ev_o, 1'(ev));
    if (md == 2 || md == 3) chk(arm_o, 1'(st == 1));
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    #100000;
    fail_count++;
    summarize();
  end
  initial
  begin
    lv = 100;
    hy = 20;
    tp = 10;
    bt = 0;
    repeat (16) @(negedge sys_clk_i);
    reset_i = 1'b0;
    for (int m = 0; m < 8; m++)
    begin
      cfg(m, m % 2, 0);
      foreach (list[i]) smp(list[i]);
      $display("test mode %0d done", m);
    end
    cfg(2, 0, 0);
    smp(70);
    smp(130);
    lv = 50;
    cfg(1, 0, 0);
    smp(60);
    smp(70);
    @(negedge sys_clk_i);
    reset_i = 1'b1;
    @(negedge sys_clk_i);
    chk(ev_o, 1'b0);
    reset_i = 1'b0;
    $display("test reference and reset done");
    lv = 32766;
    cfg(1, 2, 2);
    smp(16384);
    smp(8191);
    lv = 0;
    cfg(1, 3, 0);
    repeat (16)
    begin
      seed = lfsr(seed);
      gain = 3'(seed[1:0]);
      smp(int'($signed(seed)));
    end
    $display("test channel path done");
    summarize();
  end
endmodule
